// ---- core/temp_regs_pkg.sv ----
package temp_regs_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_LOCAL_TEMP        = 8'h00;
    localparam logic [7:0] ADDR_REMOTE_TEMP_HIGH  = 8'h01;
    localparam logic [7:0] ADDR_LOCAL_HIGH_LIMIT  = 8'h05;
    localparam logic [7:0] ADDR_REMOTE_LIMIT_HIGH = 8'h07;
    localparam logic [7:0] ADDR_REMOTE_TEMP_LOW   = 8'h10;
    localparam logic [7:0] ADDR_OFFSET_HIGH       = 8'h11;
    localparam logic [7:0] ADDR_OFFSET_LOW        = 8'h12;
    localparam logic [7:0] ADDR_REMOTE_LIMIT_LOW  = 8'h13;
    localparam logic [7:0] ADDR_REMOTE_LOW_HIGH   = 8'h08;
    localparam logic [7:0] ADDR_REMOTE_LOW_LOW    = 8'h14;
    localparam logic [7:0] ADDR_CONFIG            = 8'h20;
    localparam logic [7:0] ADDR_IRQ_STATUS        = 8'h21;
    localparam logic [7:0] ADDR_IRQ_ENABLE        = 8'h22;
    localparam logic [7:0] ADDR_IRQ_CLEAR         = 8'h23;

    // ------------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------------
    localparam int         FRAC_MSB           = 7;
    localparam int         FRAC_LSB           = 5;
    localparam logic [7:0] FRAC_MASK          = 8'hE0;
    localparam logic [7:0] RESET_HIGH_LIMIT   = 8'h46;
    localparam logic [7:0] RESET_ZERO         = 8'h00;
    localparam int         CFG_QUEUE_BIT      = 0;
    localparam int         IRQ_BITS           = 3;
    localparam int         IRQ_REMOTE_HIGH    = 0;
    localparam int         IRQ_REMOTE_LOW     = 1;
    localparam int         IRQ_LOCAL_HIGH     = 2;
    localparam logic [1:0] QUEUE_DEPTH        = 2'h2;

endpackage : temp_regs_pkg

// ---- core/temp_regs.sv ----
// Implementation choice: strobed register access.
`timescale 1ns/1ps

module temp_regs
    import temp_regs_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                rst_n,
    input  wire logic [7:0]          addr,
    input  wire logic [7:0]          wdata,
    input  wire logic                wr,
    input  wire logic                rd,
    output logic      [7:0]          rdata,
    input  wire logic [7:0]          local_sample,
    input  wire logic                local_valid,
    input  wire logic [10:0]         adc_sample,
    input  wire logic                adc_valid,
    output logic                     irq
);
    import temp_regs_pkg::*;

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]          local_temp;
        logic [10:0]         remote_temp;
        logic [2:0]          low_latch;
        logic [7:0]          local_limit;
        logic [10:0]         remote_limit;
        logic [10:0]         remote_low_limit;
        logic [10:0]         offset;
        logic [7:0]          config_reg;
        logic [1:0]          over_count;
        logic [1:0]          under_count;
        logic [IRQ_BITS-1:0] status;
        logic [IRQ_BITS-1:0] enable;
        logic [7:0]          rdata;
        logic                irq;
    } state_type;

    state_type state;
    state_type next_state;

    // Signed compare of two 11-bit readings
    function automatic logic above(input logic [10:0] a, input logic [10:0] b);
        above = $signed(a) > $signed(b);
    endfunction : above

    function automatic logic [7:0] low_byte(input logic [2:0] f);
        low_byte = {f, 5'h00};
    endfunction : low_byte

    logic [10:0]         corrected;
    logic                is_over;
    logic                is_under;
    logic [IRQ_BITS-1:0] events;
    logic [IRQ_BITS-1:0] clear_bits;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        next_state = state;
        corrected  = adc_sample + state.offset;
        is_over    = above(corrected, state.remote_limit);
        is_under   = above(state.remote_low_limit, corrected);
        events     = '0;
        clear_bits = '0;

        if (local_valid) begin
            next_state.local_temp = local_sample;
            events[IRQ_LOCAL_HIGH] = above({local_sample, 3'h0}, {state.local_limit, 3'h0});
        end

        if (adc_valid) begin
            next_state.remote_temp = corrected;
            next_state.over_count  = is_over ? ((state.over_count == QUEUE_DEPTH) ?
                                     QUEUE_DEPTH : state.over_count + 2'h1) : 2'h0;
            next_state.under_count = is_under ? ((state.under_count == QUEUE_DEPTH) ?
                                     QUEUE_DEPTH : state.under_count + 2'h1) : 2'h0;
            if (!state.config_reg[CFG_QUEUE_BIT]) begin
                events[IRQ_REMOTE_HIGH] = is_over;
                events[IRQ_REMOTE_LOW]  = is_under;
            end else begin
                // Three in a row when queueing
                events[IRQ_REMOTE_HIGH] = is_over && (state.over_count == QUEUE_DEPTH);
                events[IRQ_REMOTE_LOW]  = is_under && (state.under_count == QUEUE_DEPTH);
            end
        end

        if (wr) begin
            case (addr)
                ADDR_LOCAL_HIGH_LIMIT:  next_state.local_limit = wdata;
                ADDR_REMOTE_LIMIT_HIGH: next_state.remote_limit[10:3] = wdata;
                ADDR_REMOTE_LIMIT_LOW:  next_state.remote_limit[2:0] = wdata[FRAC_MSB:FRAC_LSB];
                ADDR_REMOTE_LOW_HIGH:   next_state.remote_low_limit[10:3] = wdata;
                ADDR_REMOTE_LOW_LOW:    next_state.remote_low_limit[2:0] =
                                            wdata[FRAC_MSB:FRAC_LSB];
                ADDR_OFFSET_HIGH:       next_state.offset[10:3] = wdata;
                ADDR_OFFSET_LOW:        next_state.offset[2:0] = wdata[FRAC_MSB:FRAC_LSB];
                ADDR_CONFIG:            next_state.config_reg = wdata;
                ADDR_IRQ_ENABLE:        next_state.enable = wdata[IRQ_BITS-1:0];
                ADDR_IRQ_CLEAR:         clear_bits = wdata[IRQ_BITS-1:0];
                default:                next_state.config_reg = state.config_reg;
            endcase
        end

        // Set wins over clear
        next_state.status = (state.status & ~clear_bits) | events;

        next_state.rdata = 8'h00;
        if (rd) begin
            case (addr)
                ADDR_LOCAL_TEMP:        next_state.rdata = state.local_temp;
                ADDR_REMOTE_TEMP_HIGH:  next_state.rdata = state.remote_temp[10:3];
                ADDR_REMOTE_TEMP_LOW:   next_state.rdata = low_byte(state.low_latch);
                ADDR_LOCAL_HIGH_LIMIT:  next_state.rdata = state.local_limit;
                ADDR_REMOTE_LIMIT_HIGH: next_state.rdata = state.remote_limit[10:3];
                ADDR_REMOTE_LIMIT_LOW:  next_state.rdata = low_byte(state.remote_limit[2:0]);
                ADDR_REMOTE_LOW_HIGH:   next_state.rdata = state.remote_low_limit[10:3];
                ADDR_REMOTE_LOW_LOW:    next_state.rdata =
                                            low_byte(state.remote_low_limit[2:0]);
                ADDR_OFFSET_HIGH:       next_state.rdata = state.offset[10:3];
                ADDR_OFFSET_LOW:        next_state.rdata = low_byte(state.offset[2:0]);
                ADDR_CONFIG:            next_state.rdata = state.config_reg;
                ADDR_IRQ_STATUS:        next_state.rdata = {5'h00, state.status};
                ADDR_IRQ_ENABLE:        next_state.rdata = {5'h00, state.enable};
                default:                next_state.rdata = 8'h00;
            endcase
            // snapshot low byte on high read
            // Relies on host order so both bytes pair up
            if (addr == ADDR_REMOTE_TEMP_HIGH) begin
                next_state.low_latch = state.remote_temp[2:0];
            end
        end

        next_state.irq = |(next_state.status & next_state.enable);
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state                  <= '0;
            state.local_limit      <= RESET_HIGH_LIMIT;
            state.remote_limit     <= {RESET_HIGH_LIMIT, 3'h0};
            state.remote_low_limit <= 11'h000;
            state.offset           <= 11'h000;
        end else begin
            state <= next_state;
        end
    end

    assign rdata = state.rdata;
    assign irq   = state.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    sequence high_read_s;
        rd && addr == ADDR_REMOTE_TEMP_HIGH;
    endsequence

    a_local_read_value: assert property (@(posedge clk) disable iff (!rst_n)
        rd && addr == ADDR_LOCAL_TEMP |=> rdata == $past(state.local_temp))
        else $error("local reading mismatch");

    a_local_limit_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == ADDR_LOCAL_HIGH_LIMIT |=> state.local_limit == $past(wdata))
        else $error("local limit not written");

    a_remote_high_byte: assert property (@(posedge clk) disable iff (!rst_n)
        high_read_s |=> rdata == $past(state.remote_temp[10:3]))
        else $error("remote high byte wrong");

    a_remote_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
        rd && addr == ADDR_REMOTE_TEMP_LOW |=> rdata[4:0] == 5'h00)
        else $error("low byte bits 4:0 not zero");

    a_offset_applied: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid |=> state.remote_temp == 11'($past(adc_sample) + $past(state.offset)))
        else $error("offset not applied");

    a_remote_limit_low: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == ADDR_REMOTE_LIMIT_LOW
        |=> state.remote_limit[2:0] == $past(wdata[FRAC_MSB:FRAC_LSB]))
        else $error("remote limit low byte wrong");

    a_alert_on_over: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid && !state.config_reg[CFG_QUEUE_BIT] && is_over
        |=> state.status[IRQ_REMOTE_HIGH])
        else $error("over alert missing");

    a_pair_capture: assert property (@(posedge clk) disable iff (!rst_n)
        high_read_s ##1 (rd && addr == ADDR_REMOTE_TEMP_LOW)
        |=> rdata[7:5] == $past(state.remote_temp[2:0], 2))
        else $error("low byte not paired");

    a_irq_level: assert property (@(posedge clk) disable iff (!rst_n)
        irq == |(state.status & state.enable))
        else $error("irq does not follow status");

    // ------------------------------------------------------------------
    // Register access checks
    // ------------------------------------------------------------------

    // Read data only stands in the cycle after a read strobe
    a_rdata_idle_zero: assert property (@(posedge clk) disable iff (!rst_n)
        !rd |=> rdata == 8'h00)
        else $error("read data not zero when idle");

    a_local_read_only: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == ADDR_LOCAL_TEMP && !local_valid |=> $stable(state.local_temp))
        else $error("local reading changed by a write");

    a_local_limit_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd && addr == ADDR_LOCAL_HIGH_LIMIT |=> rdata == $past(state.local_limit))
        else $error("local limit read wrong");

    a_remote_read_only: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == ADDR_REMOTE_TEMP_HIGH && !adc_valid |=> $stable(state.remote_temp))
        else $error("remote reading changed by a write");

    a_remote_low_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd && addr == ADDR_REMOTE_TEMP_LOW |=> rdata[7:5] == $past(state.low_latch))
        else $error("remote fraction read wrong");

    a_offset_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
        rd && addr == ADDR_OFFSET_LOW |=> rdata[4:0] == 5'h00)
        else $error("offset low bits 4:0 not zero");

    a_offset_high_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == ADDR_OFFSET_HIGH |=> state.offset[10:3] == $past(wdata))
        else $error("offset high byte not written");

    a_offset_low_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == ADDR_OFFSET_LOW
        |=> state.offset[2:0] == $past(wdata[FRAC_MSB:FRAC_LSB]))
        else $error("offset low byte not written");

    a_limit_high_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == ADDR_REMOTE_LIMIT_HIGH |=> state.remote_limit[10:3] == $past(wdata))
        else $error("remote limit high byte not written");

    a_limit_low_zero: assert property (@(posedge clk) disable iff (!rst_n)
        rd && addr == ADDR_REMOTE_LIMIT_LOW |=> rdata[4:0] == 5'h00)
        else $error("remote limit low bits 4:0 not zero");

    a_low_limit_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == ADDR_REMOTE_LOW_HIGH |=> state.remote_low_limit[10:3] == $past(wdata))
        else $error("remote low limit not written");

    a_config_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == ADDR_CONFIG |=> state.config_reg == $past(wdata))
        else $error("config not written");

    a_enable_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == ADDR_IRQ_ENABLE |=> state.enable == $past(wdata[IRQ_BITS-1:0]))
        else $error("enable not written");

    a_status_read: assert property (@(posedge clk) disable iff (!rst_n)
        rd && addr == ADDR_IRQ_STATUS |=> rdata == {5'h00, $past(state.status)})
        else $error("status read wrong");

    // Latch must not move between the two reads of a pair
    a_latch_held: assert property (@(posedge clk) disable iff (!rst_n)
        !high_read_s |=> $stable(state.low_latch))
        else $error("fraction latch moved without a high read");

    // ------------------------------------------------------------------
    // Alert checks
    // ------------------------------------------------------------------

    sequence queue_third_s;
        adc_valid && state.config_reg[CFG_QUEUE_BIT] && is_over
            && state.over_count == QUEUE_DEPTH;
    endsequence

    sequence queue_early_s;
        adc_valid && state.config_reg[CFG_QUEUE_BIT] && is_over
            && state.over_count != QUEUE_DEPTH && !state.status[IRQ_REMOTE_HIGH];
    endsequence

    a_alert_on_under: assert property (@(posedge clk) disable iff (!rst_n)
        adc_valid && !state.config_reg[CFG_QUEUE_BIT] && is_under
        |=> state.status[IRQ_REMOTE_LOW])
        else $error("under alert missing");

    a_queue_third: assert property (@(posedge clk) disable iff (!rst_n)
        queue_third_s |=> state.status[IRQ_REMOTE_HIGH])
        else $error("queued alert missing on third result");

    // Queueing filters single spikes; earlier results must stay quiet
    a_queue_early: assert property (@(posedge clk) disable iff (!rst_n)
        queue_early_s |=> !state.status[IRQ_REMOTE_HIGH])
        else $error("queued alert raised too early");

    a_local_alert: assert property (@(posedge clk) disable iff (!rst_n)
        local_valid && above({local_sample, 3'h0}, {state.local_limit, 3'h0})
        |=> state.status[IRQ_LOCAL_HIGH])
        else $error("local alert missing");

    a_status_sticky: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1 |=> (state.status & $past(state.status & ~clear_bits))
                 == $past(state.status & ~clear_bits))
        else $error("status bit lost without a clear");

    // Set beats clear so no event is ever lost
    a_set_wins: assert property (@(posedge clk) disable iff (!rst_n)
        |events |=> (state.status & $past(events)) == $past(events))
        else $error("event lost to a clear");

    a_clear_works: assert property (@(posedge clk) disable iff (!rst_n)
        wr && addr == ADDR_IRQ_CLEAR && events == '0
        |=> (state.status & $past(wdata[IRQ_BITS-1:0])) == '0)
        else $error("status clear did not take");

endmodule : temp_regs

// ---- bench/sensor_feed.sv ----
`timescale 1ns/1ps

module sensor_feed (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        push_local,
    input  wire logic        push_remote,
    input  wire logic [10:0] value,
    output logic      [7:0]  local_sample,
    output logic             local_valid,
    output logic      [10:0] adc_sample,
    output logic             adc_valid
);
    // Samples toggle outside valid so stale data is never mistaken for fresh
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            local_valid  <= 1'b0;
            adc_valid    <= 1'b0;
            local_sample <= 8'h00;
            adc_sample   <= 11'h000;
        end else begin
            local_valid  <= push_local;
            adc_valid    <= push_remote;
            local_sample <= push_local ? value[7:0] : ~local_sample;
            adc_sample   <= push_remote ? value : ~adc_sample;
        end
    end
endmodule : sensor_feed

// ---- bench/test_temp_regs.sv ----
`timescale 1ns/1ps
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp); end end

module test_temp_regs;
    import temp_regs_pkg::*;
    logic        clk, rst_n, wr, rd, push_local, push_remote, local_valid, adc_valid, irq;
    logic [7:0]  addr, wdata, rdata, local_sample;
    logic [10:0] value, adc_sample;
    int          n_mismatch, checks_done, i;
    logic [7:0]  rst_addr [7] = '{8'h05, 8'h07, 8'h13, 8'h11, 8'h12, 8'h21, 8'h30};
    logic [7:0]  rst_exp  [7] = '{8'h46, 8'h46, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    temp_regs u_temp_regs (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .local_sample(local_sample), .local_valid(local_valid),
        .adc_sample(adc_sample), .adc_valid(adc_valid), .irq(irq));
    sensor_feed u_sensor_feed (.clk(clk), .rst_n(rst_n), .push_local(push_local),
        .push_remote(push_remote), .value(value), .local_sample(local_sample),
        .local_valid(local_valid), .adc_sample(adc_sample), .adc_valid(adc_valid));

    // ------------------------------------------------------------------
    // Bus tasks
    // ------------------------------------------------------------------
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); wr <= 1'b1; addr <= a; wdata <= d;
        @(posedge clk); wr <= 1'b0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk); rd <= 1'b1; addr <= a;
        @(posedge clk); rd <= 1'b0;
        #1 `CHK(rdata, e)
    endtask : rd_reg

    // Status settles one cycle after the valid pulse lands
    task automatic push(input logic remote, input logic [10:0] v);
        @(posedge clk); push_remote <= remote; push_local <= !remote; value <= v;
        @(posedge clk); push_remote <= 1'b0; push_local <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : push

    // High then low read back to back, as a host pair
    task automatic rd_pair(input logic [7:0] eh, input logic [7:0] el);
        @(posedge clk); rd <= 1'b1; addr <= 8'h01;
        @(posedge clk); addr <= 8'h10;
        #1 `CHK(rdata, eh)
        @(posedge clk); rd <= 1'b0;
        #1 `CHK(rdata, el)
    endtask : rd_pair

    // Host must fetch the high byte first so the fraction is latched
    task automatic check_remote(input logic [10:0] adc, input logic [10:0] off);
        logic [10:0] r;
        r = adc + off;
        push(1'b1, adc);
        rd_pair(r[10:3], {r[2:0], 5'h00});
    endtask : check_remote

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : report_and_stop

    // ------------------------------------------------------------------
    // Stimulus
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    initial begin
        #20000;
        n_mismatch++;
        report_and_stop();
    end

    initial begin
        n_mismatch = 0; checks_done = 0; rst_n = 1'b0; wr = 1'b0; rd = 1'b0;
        addr = 8'h00; wdata = 8'h00; push_local = 1'b0; push_remote = 1'b0; value = 11'h000;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 7; i++) rd_reg(rst_addr[i], rst_exp[i]);
        $display("test reset_values done");
        push(1'b0, 11'h02D);
        rd_reg(8'h00, 8'h2D);
        wr_reg(8'h00, 8'hFF);
        rd_reg(8'h00, 8'h2D);
        wr_reg(8'h05, 8'h55);
        rd_reg(8'h05, 8'h55);
        wr_reg(8'h07, 8'h10);
        wr_reg(8'h13, 8'hFF);
        rd_reg(8'h07, 8'h10);
        rd_reg(8'h13, 8'hE0);
        $display("test local_and_limits done");
        check_remote(11'h4B5, 11'h000);
        push(1'b1, 11'h123);
        rd_reg(8'h10, 8'hA0);
        wr_reg(8'h11, 8'h02);
        wr_reg(8'h12, 8'hFF);
        rd_reg(8'h12, 8'hE0);
        check_remote(11'h010, 11'h017);
        check_remote(11'h7FF, 11'h017);
        $display("test remote_reading done");
        wr_reg(8'h11, 8'h00);
        wr_reg(8'h12, 8'h00);
        wr_reg(8'h13, 8'h00);
        wr_reg(8'h20, 8'h00);
        wr_reg(8'h23, 8'h07);
        wr_reg(8'h22, 8'h03);
        push(1'b1, 11'h0F8);
        #1 `CHK(irq, 1'b1)
        rd_reg(8'h21, 8'h01);
        wr_reg(8'h22, 8'h00);
        #1 `CHK(irq, 1'b0)
        wr_reg(8'h22, 8'h03);
        wr_reg(8'h23, 8'h01);
        rd_reg(8'h21, 8'h00);
        `CHK(irq, 1'b0)
        push(1'b1, 11'h7F8);
        #1 `CHK(irq, 1'b1)
        rd_reg(8'h21, 8'h02);
        $display("test alert done");
        wr_reg(8'h23, 8'h07);
        wr_reg(8'h20, 8'h01);
        push(1'b1, 11'h0F8);
        push(1'b1, 11'h0F8);
        rd_reg(8'h21, 8'h00);
        push(1'b1, 11'h0F8);
        rd_reg(8'h21, 8'h01);
        $display("test queue done");
        wr_reg(8'h23, 8'h07);
        wr_reg(8'h22, 8'h04);
        push(1'b0, 11'h060);
        #1 `CHK(irq, 1'b1)
        rd_reg(8'h21, 8'h04);
        $display("test local_alert done");
        report_and_stop();
    end
endmodule : test_temp_regs
